/* File: dv/lpic_checker_sva.sv */
// concurrent checks on the ports of the interrupt and calibration block
module lpic_checker #(
    parameter int AMB_W   = 20,
    parameter int COUNT_W = 20
) (
    // clock and reset
    input wire logic               clock_i,
    input wire logic               rst_i,
    // register port
    input wire logic [7:0]         reg_addr_i,
    input wire logic               reg_wr_i,
    input wire logic [7:0]         reg_wdata_i,
    input wire logic               reg_rd_i,
    input wire logic               read_busy_i,
    input wire logic [7:0]         reg_rdata_o,
    input wire logic               reg_hit_o,
    // measurements
    input wire logic               status_read_i,
    input wire logic               ambient_valid_i,
    input wire logic [AMB_W-1:0]   ambient_raw_i,
    input wire logic [COUNT_W-1:0] infrared_count_i,
    input wire logic [COUNT_W-1:0] clear_channel_count_i,
    // results
    input wire logic [AMB_W-1:0]   ambient_result_o,
    input wire logic               ambient_result_valid_o,
    input wire logic [15:0]        ch2_weight_o,
    input wire logic [7:0]         infrared_ratio_limit_o,
    input wire logic               prox_flag_o,
    input wire logic               int_oe_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // products kept full width so a large count cannot wrap the compare
    logic [COUNT_W+7:0] ir_scaled;
    logic [COUNT_W+7:0] lim_scaled;
    logic               over;
    logic               ctl_off;
    assign ir_scaled  = {infrared_count_i, 8'h00};
    assign lim_scaled = infrared_ratio_limit_o * clear_channel_count_i;
    assign over       = ir_scaled > lim_scaled;
    assign ctl_off    = reg_wdata_i[1:0] == 2'b00;
    sequence low_write_s;
        reg_wr_i && reg_addr_i == 8'h95 && !read_busy_i;
    endsequence
    sequence ctl_write_s;
        reg_wr_i && reg_addr_i == 8'h98;
    endsequence
    reset_values_a: assert property ($past(rst_i) |-> ch2_weight_o == 16'hFBC8 &&
        infrared_ratio_limit_o == 8'hD0) else $error("reset value wrong");
    weight_freeze_a: assert property (read_busy_i |=> $stable(ch2_weight_o))
        else $error("weight moved during a read");
    weight_copy_a: assert property (low_write_s ##1 !read_busy_i |=>
        ch2_weight_o[7:0] == $past(reg_wdata_i, 2)) else $error("weight copy missing");
    ratio_zero_a: assert property (ambient_valid_i && over |=>
        ambient_result_o == '0 && ambient_result_valid_o) else $error("ambient not zeroed");
    ratio_pass_a: assert property (ambient_valid_i && !over |=>
        ambient_result_o == $past(ambient_raw_i)) else $error("ambient altered");
    pin_enable_a: assert property (ctl_write_s |-> ##2
        int_oe_n_o == $past(ctl_off, 2)) else $error("pin enable wrong");
    mask_read_a: assert property (reg_rd_i && (reg_addr_i == 8'h9A ||
        reg_addr_i == 8'h9C) |=> reg_hit_o && reg_rdata_o[7:3] == 5'h00)
        else $error("ignored bits read back");
    flag_sticky_a: assert property (prox_flag_o && !status_read_i |=> prox_flag_o)
        else $error("status flag lost");
endmodule

bind lpic_interrupt_calib lpic_checker #(.AMB_W(AMB_W), .COUNT_W(COUNT_W)) chk_u (
    .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .read_busy_i(read_busy_i),
    .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o), .status_read_i(status_read_i),
    .ambient_valid_i(ambient_valid_i), .ambient_raw_i(ambient_raw_i),
    .infrared_count_i(infrared_count_i), .clear_channel_count_i(clear_channel_count_i),
    .ambient_result_o(ambient_result_o), .ambient_result_valid_o(ambient_result_valid_o),
    .ch2_weight_o(ch2_weight_o), .infrared_ratio_limit_o(infrared_ratio_limit_o),
    .prox_flag_o(prox_flag_o), .int_oe_n_o(int_oe_n_o));

/* File: dv/lpic_host_model.sv */
// host side: register strobes, status read and pulled-up interrupt pin
module lpic_host_model (
    // clock
    input  wire logic       clock_i,
    // register port
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o,
    output logic            read_busy_o,
    output logic            status_read_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_hit_i,
    // interrupt pin
    input  wire logic       int_i,
    input  wire logic       int_oe_n_i,
    output logic            int_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic hold_busy = 1'b0;
    initial begin
        {reg_addr_o, reg_wr_o, reg_wdata_o, reg_rd_o, read_busy_o, status_read_o} = '0;
    end
    assign int_pin_o = int_oe_n_i ? 1'b1 : int_i;
    // idle lines show inverted values so stale data cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
        @(negedge clock_i);
        {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic h);
        @(negedge clock_i);
        {reg_addr_o, reg_rd_o, read_busy_o} = {a, 2'b11};
        @(negedge clock_i);
        {reg_addr_o, reg_rd_o, read_busy_o} = {~a, 1'b0, hold_busy};
        q = reg_rdata_i;
        h = reg_hit_i;
    endtask
    task automatic st();
        @(negedge clock_i);
        status_read_o = 1'b1;
        @(negedge clock_i);
        status_read_o = 1'b0;
    endtask
    task automatic busy(input logic b);
        @(negedge clock_i);
        hold_busy   = b;
        read_busy_o = b;
    endtask
endmodule

/* File: dv/tb_light_prox_interrupt_calib.sv */
// self-checking bench for the interrupt and calibration block
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
$display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_light_prox_interrupt_calib;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [7:0] a, d, r, w; logic h;} lpic_row_type;
    lpic_row_type rows [10] = '{'{8'h95, 8'hA5, 8'hC8, 8'hA5, 1'b1},
        '{8'h96, 8'h3C, 8'hFB, 8'h3C, 1'b1}, '{8'h97, 8'h40, 8'hD0, 8'h40, 1'b1},
        '{8'h98, 8'hFF, 8'h08, 8'h0F, 1'b1}, '{8'h99, 8'h64, 8'hFF, 8'h64, 1'b1},
        '{8'h9A, 8'hF8, 8'h07, 8'h00, 1'b1}, '{8'h9B, 8'h0A, 8'h00, 8'h0A, 1'b1},
        '{8'h9C, 8'hF8, 8'h00, 8'h00, 1'b1}, '{8'h94, 8'h55, 8'h00, 8'h00, 1'b0},
        '{8'h9D, 8'h55, 8'h00, 8'h00, 1'b0}};
    logic        clock_i = 1'b0, rst_i = 1'b1, prox_valid = 1'b0, amb_valid = 1'b0;
    logic        amb_out = 1'b0;
    logic [10:0] prox_res = 11'h000;
    logic [19:0] ir = 20'h0_0000, clr = 20'h0_0001, amb_res;
    logic [3:0]  p_persist = 4'h0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, limit, rd;
    logic        reg_wr, reg_rd, read_busy, status_read, reg_hit, hit, exp_pin;
    logic        amb_rv, pflag, aflag, int_o, int_oe_n, pin;
    logic [15:0] weight;
    int          checked = 0, failures = 0, cycles = 0;
    always #5 clock_i = ~clock_i;
    lpic_interrupt_calib dut_u (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
        .read_busy_i(read_busy), .reg_rdata_o(reg_rdata), .reg_hit_o(reg_hit),
        .status_read_i(status_read), .prox_persist_i(p_persist), .ambient_persist_i(p_persist),
        .prox_valid_i(prox_valid), .proximity_result_i(prox_res),
        .ambient_valid_i(amb_valid), .ambient_outside_i(amb_out),
        .ambient_raw_i(20'h1_2345), .infrared_count_i(ir), .clear_channel_count_i(clr),
        .ambient_result_o(amb_res), .ambient_result_valid_o(amb_rv),
        .ch2_weight_o(weight), .infrared_ratio_limit_o(limit), .prox_flag_o(pflag),
        .ambient_flag_o(aflag), .int_o(int_o), .int_oe_n_o(int_oe_n));
    lpic_host_model host_u (.clock_i(clock_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .read_busy_o(read_busy),
        .status_read_o(status_read), .reg_rdata_i(reg_rdata), .reg_hit_i(reg_hit),
        .int_i(int_o), .int_oe_n_i(int_oe_n), .int_pin_o(pin));
    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // pin settles two edges after the strobe, so one spare cycle is waited
    task automatic prox(input logic [10:0] v);
        @(negedge clock_i);
        {prox_valid, prox_res} = {1'b1, v};
        @(negedge clock_i);
        {prox_valid, prox_res} = {1'b0, ~v};
        @(negedge clock_i);
    endtask
    task automatic amb(input logic [19:0] i, input logic [19:0] c, input logic o);
        @(negedge clock_i);
        {amb_valid, ir, clr, amb_out} = {1'b1, i, c, o};
        @(negedge clock_i);
        {amb_valid, amb_out} = 2'b00;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        repeat (3) @(negedge clock_i);
        rst_i = 1'b0;
        foreach (rows[i]) begin
            host_u.rd(rows[i].a, rd, hit);
            `CHK("reset value", rows[i].r, rd)
            `CHK("hit", rows[i].h, hit)
            host_u.wr(rows[i].a, rows[i].d);
            host_u.rd(rows[i].a, rd, hit);
            `CHK("readback", rows[i].w, rd)
        end
        `CHK("weight", 16'h3CA5, weight)
        `CHK("limit", 8'h40, limit)
        host_u.busy(1'b1);
        host_u.wr(8'h95, 8'h11);
        repeat (3) @(negedge clock_i);
        `CHK("frozen", 16'h3CA5, weight)
        host_u.busy(1'b0);
        repeat (2) @(negedge clock_i);
        `CHK("copied", 16'h3C11, weight)
        amb(20'h0_001E, 20'h0_0064, 1'b0);
        `CHK("cut", 20'h0_0000, amb_res)
        `CHK("valid", 1'b1, amb_rv)
        amb(20'h0_0019, 20'h0_0064, 1'b0);
        `CHK("kept", 20'h1_2345, amb_res)
        for (int k = 0; k < 8; k++) begin
            host_u.wr(8'h98, 8'h0B);
            prox(11'h032);
            host_u.wr(8'h98, {5'h01, k[2:0]});
            prox(11'h005);
            exp_pin = (k[1:0] == 2'b00) ? 1'b1 : (k[0] ? k[2] : !k[2]);
            `CHK("pin", exp_pin, pin)
            `CHK("status", 1'b1, pflag)
        end
        host_u.wr(8'h98, 8'h05);
        prox(11'h005);
        prox(11'h032);
        `CHK("latched", 1'b1, pin)
        host_u.st();
        repeat (2) @(negedge clock_i);
        `CHK("cleared", 1'b0, pin)
        `CHK("flag cleared", 1'b0, pflag)
        host_u.wr(8'h98, 8'h0D);
        p_persist = 4'h3;
        prox(11'h065);
        prox(11'h065);
        `CHK("persist early", 1'b0, pin)
        prox(11'h065);
        `CHK("persist met", 1'b1, pin)
        prox(11'h064);
        `CHK("upper edge", 1'b0, pin)
        p_persist = 4'h0;
        prox(11'h00A);
        `CHK("lower edge", 1'b0, pin)
        host_u.wr(8'h98, 8'h0E);
        p_persist = 4'h2;
        amb(20'h0_0001, 20'h0_0064, 1'b1);
        @(negedge clock_i);
        `CHK("ambient early", 1'b0, pin)
        amb(20'h0_0001, 20'h0_0064, 1'b1);
        @(negedge clock_i);
        `CHK("ambient pin", 1'b1, pin)
        `CHK("ambient flag", 1'b1, aflag)
        rst_i = 1'b1;
        @(negedge clock_i);
        rst_i = 1'b0;
        `CHK("weight reset", 16'hFBC8, weight)
        `CHK("pin floats", 1'b1, int_oe_n)
        wrap_up();
    end
endmodule

/* File: hdl/lpic_interrupt_calib.sv */
// interrupt control, infrared cut-off and proximity window of the light sensor
module lpic_interrupt_calib
    import lpic_pkg::*;
#(
    parameter int AMB_W      = 20,
    parameter int COUNT_W    = 20,
    parameter int RATIO_FRAC = 8
) (
    // clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      rst_i,
    // register port from the serial slave
    input  wire logic [7:0]                reg_addr_i,
    input  wire logic                      reg_wr_i,
    input  wire logic [7:0]                reg_wdata_i,
    input  wire logic                      reg_rd_i,
    input  wire logic                      read_busy_i,
    output logic      [7:0]                reg_rdata_o,
    output logic                           reg_hit_o,
    // status register access and persistence setting
    input  wire logic                      status_read_i,
    input  wire logic [LPIC_PERSIST_W-1:0] prox_persist_i,
    input  wire logic [LPIC_PERSIST_W-1:0] ambient_persist_i,
    // proximity measurement
    input  wire logic                      prox_valid_i,
    input  wire logic [LPIC_PROX_W-1:0]    proximity_result_i,
    // ambient measurement
    input  wire logic                      ambient_valid_i,
    input  wire logic                      ambient_outside_i,
    input  wire logic [AMB_W-1:0]          ambient_raw_i,
    input  wire logic [COUNT_W-1:0]        infrared_count_i,
    input  wire logic [COUNT_W-1:0]        clear_channel_count_i,
    // results to the rest of the device
    output logic      [AMB_W-1:0]          ambient_result_o,
    output logic                           ambient_result_valid_o,
    output logic      [15:0]               ch2_weight_o,
    output logic      [7:0]                infrared_ratio_limit_o,
    // status flags
    output logic                           prox_flag_o,
    output logic                           ambient_flag_o,
    // interrupt pin
    output logic                           int_o,
    output logic                           int_oe_n_o
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]                   infrared_ratio_limit;
    logic [LPIC_CTL_USED_MSB:0]   interrupt_control;
    logic [7:0]                   prox_upper_limit_low;
    logic [LPIC_LIMIT_HIGH_W-1:0] prox_upper_limit_high;
    logic [7:0]                   prox_lower_limit_low;
    logic [LPIC_LIMIT_HIGH_W-1:0] prox_lower_limit_high;

    logic                         wr_weight_low;
    logic                         wr_weight_high;
    logic [15:0]                  ch2_weight;

    lpic_source_type              source_sel;
    logic                         polarity_high;
    logic                         per_measurement;

    assign source_sel      = lpic_source_type'(
        interrupt_control[LPIC_CTL_MODE_MSB:LPIC_CTL_MODE_LSB]);
    assign polarity_high   = interrupt_control[LPIC_CTL_POLARITY_BIT];
    assign per_measurement = interrupt_control[LPIC_CTL_OUTPUT_BIT];

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // host writes the weight
    assign wr_weight_low  = reg_wr_i && (reg_addr_i == LPIC_ADDR_WEIGHT_LOW);
    assign wr_weight_high = reg_wr_i && (reg_addr_i == LPIC_ADDR_WEIGHT_HIGH);

    lpic_weight_shadow u_weight (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .wr_low_i    (wr_weight_low),
        .wr_high_i   (wr_weight_high),
        .wdata_i     (reg_wdata_i),
        .read_busy_i (read_busy_i),
        .weight_o    (ch2_weight)
    );

    assign ch2_weight_o = ch2_weight;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            infrared_ratio_limit <= LPIC_RST_RATIO_LIMIT;
        end else if (reg_wr_i && (reg_addr_i == LPIC_ADDR_RATIO_LIMIT)) begin
            infrared_ratio_limit <= reg_wdata_i;
        end
    end

    assign infrared_ratio_limit_o = infrared_ratio_limit;

    // control default
    // reserved upper bits are not stored and read back as zero
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            interrupt_control <= LPIC_RST_INT_CONTROL[LPIC_CTL_USED_MSB:0];
        end else if (reg_wr_i && (reg_addr_i == LPIC_ADDR_INT_CONTROL)) begin
            interrupt_control <= reg_wdata_i[LPIC_CTL_USED_MSB:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            prox_upper_limit_low  <= LPIC_RST_UPPER_LOW;
            prox_upper_limit_high <= LPIC_RST_UPPER_HIGH;
            prox_lower_limit_low  <= LPIC_RST_LOWER_LOW;
            prox_lower_limit_high <= LPIC_RST_LOWER_HIGH;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                LPIC_ADDR_UPPER_LOW: begin
                    prox_upper_limit_low <= reg_wdata_i;
                end
                LPIC_ADDR_UPPER_HIGH: begin
                    prox_upper_limit_high <= reg_wdata_i[LPIC_LIMIT_HIGH_W-1:0];
                end
                LPIC_ADDR_LOWER_LOW: begin
                    prox_lower_limit_low <= reg_wdata_i;
                end
                LPIC_ADDR_LOWER_HIGH: begin
                    prox_lower_limit_high <= reg_wdata_i[LPIC_LIMIT_HIGH_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    logic [7:0] next_rdata;
    logic       next_hit;

    always_comb begin
        next_rdata = 8'h00;
        next_hit   = 1'b1;
        unique case (reg_addr_i)
            LPIC_ADDR_WEIGHT_LOW: begin
                next_rdata = ch2_weight[7:0];
            end
            LPIC_ADDR_WEIGHT_HIGH: begin
                next_rdata = ch2_weight[15:8];
            end
            LPIC_ADDR_RATIO_LIMIT: begin
                next_rdata = infrared_ratio_limit;
            end
            LPIC_ADDR_INT_CONTROL: begin
                next_rdata = {{(7-LPIC_CTL_USED_MSB){1'b0}}, interrupt_control};
            end
            LPIC_ADDR_UPPER_LOW: begin
                next_rdata = prox_upper_limit_low;
            end
            LPIC_ADDR_UPPER_HIGH: begin
                next_rdata = {{(8-LPIC_LIMIT_HIGH_W){1'b0}}, prox_upper_limit_high};
            end
            LPIC_ADDR_LOWER_LOW: begin
                next_rdata = prox_lower_limit_low;
            end
            LPIC_ADDR_LOWER_HIGH: begin
                next_rdata = {{(8-LPIC_LIMIT_HIGH_W){1'b0}}, prox_lower_limit_high};
            end
            default: begin
                next_hit = 1'b0;
            end
        endcase
    end

    // read data held until the next read strobe
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
            reg_hit_o   <= 1'b0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
            reg_hit_o   <= next_hit;
        end
    end

    // ------------------------------------------------------------
    // infrared cut-off
    // ------------------------------------------------------------
    // compare as a product so no divider is needed; ratio has RATIO_FRAC fraction bits
    localparam int PROD_W = COUNT_W + 8 + RATIO_FRAC;

    logic [PROD_W-1:0] ir_scaled;
    logic [PROD_W-1:0] limit_scaled;
    logic              ratio_over;

    assign ir_scaled    = PROD_W'(infrared_count_i) << RATIO_FRAC;
    assign limit_scaled = PROD_W'(infrared_ratio_limit) * PROD_W'(clear_channel_count_i);
    assign ratio_over   = ir_scaled > limit_scaled;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ambient_result_o       <= '0;
            ambient_result_valid_o <= 1'b0;
        end else begin
            ambient_result_valid_o <= ambient_valid_i;
            if (ambient_valid_i) begin
                ambient_result_o <= ratio_over ? '0 : ambient_raw_i;
            end
        end
    end

    // ------------------------------------------------------------
    // proximity window
    // ------------------------------------------------------------
    logic [LPIC_PROX_W-1:0] prox_upper;
    logic [LPIC_PROX_W-1:0] prox_lower;
    logic                   prox_outside;

    assign prox_upper = {prox_upper_limit_high, prox_upper_limit_low};
    assign prox_lower = {prox_lower_limit_high, prox_lower_limit_low};

    assign prox_outside = (proximity_result_i > prox_upper) || (proximity_result_i < prox_lower);

    // ------------------------------------------------------------
    // persistence per source
    // ------------------------------------------------------------
    logic [LPIC_SOURCES-1:0]   meas_valid;
    logic [LPIC_SOURCES-1:0]   meas_outside;
    logic [LPIC_PERSIST_W-1:0] persist_need [LPIC_SOURCES];
    logic [LPIC_SOURCES-1:0]   hit;

    assign meas_valid[LPIC_SRC_PROX]      = prox_valid_i;
    assign meas_valid[LPIC_SRC_AMBIENT]   = ambient_valid_i;
    assign meas_outside[LPIC_SRC_PROX]    = prox_outside;
    assign meas_outside[LPIC_SRC_AMBIENT] = ambient_outside_i;
    assign persist_need[LPIC_SRC_PROX]    = prox_persist_i;
    assign persist_need[LPIC_SRC_AMBIENT] = ambient_persist_i;

    for (genvar s = 0; s < LPIC_SOURCES; s++) begin : g_source
        logic [LPIC_PERSIST_W-1:0] run;
        logic [LPIC_PERSIST_W-1:0] next_run;
        logic [LPIC_PERSIST_W-1:0] need;

        // a setting of zero behaves like one: each outside result counts
        assign need     = (persist_need[s] == LPIC_PERSIST_NONE) ? LPIC_PERSIST_ONE
                                                                 : persist_need[s];
        assign next_run = (run == LPIC_PERSIST_MAX) ? run : run + LPIC_PERSIST_ONE;

        always_ff @(posedge clock_i) begin
            if (rst_i) begin
                run <= LPIC_PERSIST_NONE;
            end else if (meas_valid[s]) begin
                run <= meas_outside[s] ? next_run : LPIC_PERSIST_NONE;
            end
        end

        assign hit[s] = meas_valid[s] && meas_outside[s] && (next_run >= need);
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    logic [LPIC_SOURCES-1:0] status_flag;

    // status kept even when disabled
    // a hit in the clearing cycle survives
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            status_flag <= '0;
        end else begin
            status_flag <= (status_read_i ? '0 : status_flag) | hit;
        end
    end

    assign prox_flag_o    = status_flag[LPIC_SRC_PROX];
    assign ambient_flag_o = status_flag[LPIC_SRC_AMBIENT];

    // ------------------------------------------------------------
    // interrupt state
    // ------------------------------------------------------------
    logic [LPIC_SOURCES-1:0] src_enable;
    logic                    int_active;

    always_comb begin
        unique case (source_sel)
            LPIC_SRC_OFF:       src_enable = 2'b00;
            LPIC_SRC_PROX_ONLY: src_enable = 2'b01;
            LPIC_SRC_AMB_ONLY:  src_enable = 2'b10;
            LPIC_SRC_BOTH:      src_enable = 2'b11;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            int_active <= 1'b0;
        end else if (per_measurement) begin
            if (|(meas_valid & src_enable)) begin
                int_active <= |(hit & src_enable);
            end
        end else if (|(hit & src_enable)) begin
            int_active <= 1'b1;
        end else if (status_read_i) begin
            int_active <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------
    // polarity of the pin
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            int_o      <= 1'b1;
            int_oe_n_o <= 1'b1;
        end else begin
            int_o      <= polarity_high ? int_active : !int_active;
            int_oe_n_o <= (source_sel == LPIC_SRC_OFF);
        end
    end

endmodule

/* File: hdl/lpic_pkg.sv */
// constants shared by the interrupt and calibration block
package lpic_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LPIC_ADDR_WEIGHT_LOW   = 8'h95;
    localparam logic [7:0] LPIC_ADDR_WEIGHT_HIGH  = 8'h96;
    localparam logic [7:0] LPIC_ADDR_RATIO_LIMIT  = 8'h97;
    localparam logic [7:0] LPIC_ADDR_INT_CONTROL  = 8'h98;
    localparam logic [7:0] LPIC_ADDR_UPPER_LOW    = 8'h99;
    localparam logic [7:0] LPIC_ADDR_UPPER_HIGH   = 8'h9A;
    localparam logic [7:0] LPIC_ADDR_LOWER_LOW    = 8'h9B;
    localparam logic [7:0] LPIC_ADDR_LOWER_HIGH   = 8'h9C;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LPIC_RST_WEIGHT_LOW    = 8'hC8;
    localparam logic [7:0] LPIC_RST_WEIGHT_HIGH   = 8'hFB;
    localparam logic [7:0] LPIC_RST_RATIO_LIMIT   = 8'hD0;
    localparam logic [7:0] LPIC_RST_INT_CONTROL   = 8'h08;
    localparam logic [7:0] LPIC_RST_UPPER_LOW     = 8'hFF;
    localparam logic [2:0] LPIC_RST_UPPER_HIGH    = 3'h7;
    localparam logic [7:0] LPIC_RST_LOWER_LOW     = 8'h00;
    localparam logic [2:0] LPIC_RST_LOWER_HIGH    = 3'h0;

    // ------------------------------------------------------------
    // field layout of interrupt_control
    // ------------------------------------------------------------
    localparam int LPIC_CTL_MODE_LSB     = 0;
    localparam int LPIC_CTL_MODE_MSB     = 1;
    localparam int LPIC_CTL_POLARITY_BIT = 2;
    localparam int LPIC_CTL_OUTPUT_BIT   = 3;
    localparam int LPIC_CTL_USED_MSB     = 3;

    // ------------------------------------------------------------
    // widths and sources
    // ------------------------------------------------------------
    localparam int LPIC_LIMIT_HIGH_W     = 3;
    localparam int LPIC_PROX_W           = 11;
    localparam int LPIC_PERSIST_W        = 4;
    localparam int LPIC_SOURCES          = 2;
    localparam int LPIC_SRC_PROX         = 0;
    localparam int LPIC_SRC_AMBIENT      = 1;

    localparam logic [LPIC_PERSIST_W-1:0] LPIC_PERSIST_MAX = 4'hF;
    localparam logic [LPIC_PERSIST_W-1:0] LPIC_PERSIST_ONE = 4'h1;
    localparam logic [LPIC_PERSIST_W-1:0] LPIC_PERSIST_NONE = 4'h0;

    // interrupt-source encodings
    typedef enum logic [1:0] {
        LPIC_SRC_OFF     = 2'h0,
        LPIC_SRC_PROX_ONLY = 2'h1,
        LPIC_SRC_AMB_ONLY  = 2'h2,
        LPIC_SRC_BOTH    = 2'h3
    } lpic_source_type;

endpackage

/* File: hdl/lpic_weight_shadow.sv */
// second-channel weight pair with read freeze and shadow copy
module lpic_weight_shadow
    import lpic_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // host writes
    input  wire logic        wr_low_i,
    input  wire logic        wr_high_i,
    input  wire logic [7:0]  wdata_i,
    // read in progress
    input  wire logic        read_busy_i,
    // visible pair
    output logic      [15:0] weight_o
);

    // ------------------------------------------------------------
    // shadow storage
    // ------------------------------------------------------------
    logic [15:0] shadow;
    logic        pending;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            shadow <= {LPIC_RST_WEIGHT_HIGH, LPIC_RST_WEIGHT_LOW};
        end else begin
            if (wr_low_i) begin
                shadow[7:0] <= wdata_i;
            end
            if (wr_high_i) begin
                shadow[15:8] <= wdata_i;
            end
        end
    end

    // a write in the copy cycle keeps pending so the newest byte still lands
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pending <= 1'b0;
        end else if (wr_low_i || wr_high_i) begin
            pending <= 1'b1;
        end else if (!read_busy_i) begin
            pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // visible pair
    // ------------------------------------------------------------
    // reset defaults
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            weight_o <= {LPIC_RST_WEIGHT_HIGH, LPIC_RST_WEIGHT_LOW};
        end else if (pending && !read_busy_i) begin
            weight_o <= shadow;
        end
    end

endmodule
